// [src/dwp_pkg.sv]
package dwp_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_WIPER_0 = 4'h0;
  localparam logic [3:0] ADDR_WIPER_1 = 4'h1;
  localparam logic [3:0] ADDR_USER_FIRST = 4'h2;
  localparam logic [3:0] ADDR_USER_LAST = 4'h6;
  localparam logic [3:0] ADDR_RESERVED = 4'h7;
  localparam logic [3:0] ADDR_ACCESS_CTL = 4'h8;
  localparam logic [3:0] ADDR_WRAP = 4'h8;

  // access control field positions and reset values
  localparam int ACR_VOL_BIT = 7;
  localparam int ACR_POWER_DOWN_CTRL_BIT = 6;
  localparam int ACR_WIP_BIT = 5;
  localparam logic ACR_VOL_RESET = 1'b0;
  localparam logic ACR_POWER_DOWN_CTRL_RESET = 1'b1;

  // wiper codes and storage contents after reset
  localparam logic [6:0] WIPER_MID = 7'h40;
  localparam logic [7:0] POWER_ON_VALUE_RESET = 8'h40;
  localparam logic [7:0] USER_BYTE_RESET = 8'h00;

  // identification byte
  localparam logic [3:0] ID_PREFIX = 4'hA;

  // timing
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int NV_WRITE_MS = 20;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * (SYS_CLK_HZ / 1000);
  localparam int POWER_UP_US = 10;
  localparam int POWER_UP_CYCLES = POWER_UP_US * (SYS_CLK_HZ / 1_000_000);

  // protocol states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ID = 3'b001,
    ST_REG = 3'b010,
    ST_WR = 3'b011,
    ST_RD = 3'b100
  } dwp_state_t;

  // tap switch pair of one potentiometer
  typedef struct packed {
    logic [6:0] make_tap;
    logic [6:0] main_tap;
  } dwp_tap_t;

  // access control register contents
  typedef struct packed {
    logic volatile_select;
    logic power_down_ctrl;
  } dwp_acr_t;

endpackage : dwp_pkg

// [src/dwp_pkg_unused_guard.sv]
// no logic here: the slave module holds all of it

// [src/dwp_slave.sv]
`timescale 1ns/1ns
// Operation
// (RQ1) wipers go to 40h during power-up
// (RQ2) wipers reload from power-on values afterwards
// (RQ3) wiper is a 7-bit monotonic code
// (RQ4) address 0 and 1 select pots
// (RQ5) user bytes 2-6, reserved 7, control 8
// (RQ6) volatile select steers addresses 0 and 1
// (RQ7) power-on value writes also wiper
// (RQ8) volatile select resets to zero
// (RQ9) shutdown bit ORed with pin, default one
// (RQ10) write-active bit blocks register writes
// (RQ11) slave only, never drives clock
// (RQ12) bytes shift most significant bit first
// (RQ13) data changes only while clock low
// (RQ14) data released, starts ignored during power-up
// (RQ15) ignore bus until start condition
// (RQ16) stop returns to standby
// (RQ17) ninth clock carries the acknowledge
// (RQ18) ack identification, address and write data
// (RQ19) master acks read bytes for more
// (RQ20) identification is 1010, straps, direction
// (RQ21) new tap closes before old opens
// (RQ22) write pointer increments, wraps 08h to 00h
// (RQ23) read uses repeated start, ends on nack
// (RQ24) non-volatile write starts at stop, 20ms
// (RQ25) read pointer starts at address, increments
// (RQ26) mismatching identification gets no ack
// (RQ27) reserved or missing registers read zero
// (RQ28) low five control bits read zero
module dwp_slave
  import dwp_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_strap_hi,
  input wire logic addr_strap_mid,
  input wire logic addr_strap_lo,
  input wire logic power_down_ctrl_n,
  output dwp_tap_t tap_0,
  output dwp_tap_t tap_1,
  output logic pot_shutdown,
  output logic nv_write_active
);

  // ----------------------------------------------------------------
  // link domain: sample data on each rising clock
  // ----------------------------------------------------------------
  logic link_clr;
  logic link_bit;
  logic link_tgl;
  // registered copy of reset for the link side
  always_ff @(posedge clk_sys) begin
    link_clr <= reset;
  end
  // (RQ12) bit capture at rising edge
  always_ff @(posedge scl or posedge link_clr) begin
    if (link_clr) begin
      link_bit <= 1'b1;
      link_tgl <= 1'b0;
    end else begin
      link_bit <= sda_in;
      link_tgl <= ~link_tgl;
    end
  end

  // ----------------------------------------------------------------
  // synchronisers into the system domain
  // ----------------------------------------------------------------
  logic scl_meta, scl_s, scl_d;
  logic sda_meta, sda_s, sda_d;
  logic tgl_meta, tgl_s, tgl_d, tgl_q;
  logic rxb_meta, rxb_s;
  logic [2:0] strap_meta, strap_s;
  logic power_down_ctrl_meta, power_down_ctrl_s;
  // two flops on every outside input
  always_ff @(posedge clk_sys) begin
    scl_meta <= scl;
    scl_s <= scl_meta;
    scl_d <= scl_s;
    sda_meta <= sda_in;
    sda_s <= sda_meta;
    sda_d <= sda_s;
    tgl_meta <= link_tgl;
    tgl_s <= tgl_meta;
    tgl_d <= tgl_s;
    tgl_q <= tgl_d;
    rxb_meta <= link_bit;
    rxb_s <= rxb_meta;
    strap_meta <= {addr_strap_hi, addr_strap_mid, addr_strap_lo};
    strap_s <= strap_meta;
    power_down_ctrl_meta <= power_down_ctrl_n;
    power_down_ctrl_s <= power_down_ctrl_meta;
  end

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  logic start_evt;
  logic stop_evt;
  logic scl_fall;
  logic bit_evt;
  logic powering_up;
  // (RQ15) start: data falls with clock high
  assign start_evt = scl_s & scl_d & sda_d & ~sda_s & ~powering_up;
  // (RQ16) stop: data rises with clock high
  assign stop_evt = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_fall = scl_d & ~scl_s;
  // bit data settled one cycle before this event
  assign bit_evt = tgl_d ^ tgl_q;

  // ----------------------------------------------------------------
  // power-up sequencing
  // ----------------------------------------------------------------
  logic [7:0] pu_cnt;
  logic pu_load;
  // (RQ14) power-up window ignores the bus
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pu_cnt <= 8'(POWER_UP_CYCLES);
      powering_up <= 1'b1;
    end else if (pu_cnt != 8'h00) begin
      pu_cnt <= pu_cnt - 8'h01;
    end else begin
      powering_up <= 1'b0;
    end
  end
  assign pu_load = powering_up & (pu_cnt == 8'h00);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] nv_mem [0:6];
  logic [6:0] wiper [0:1];
  dwp_acr_t access_control;
  logic [17:0] nv_cnt;
  logic nv_pending;
  logic nv_busy;
  logic [3:0] ptr;
  assign nv_busy = nv_cnt != 18'h00000;
  // pointer advance with wrap after the control register
  function automatic logic [3:0] next_ptr(input logic [3:0] p);
    next_ptr = (p >= ADDR_WRAP) ? 4'h0 : p + 4'h1;
  endfunction : next_ptr
  // read data for one pointer value
  function automatic logic [7:0] reg_read(input logic [3:0] p);
    logic [7:0] v;
    v = 8'h00;
    if (p <= ADDR_WIPER_1) begin
      // (RQ6) select wiper or power-on value
      if (access_control.volatile_select) begin
        v = {1'b0, wiper[p[0]]};
      end else begin
        v = nv_mem[p[2:0]];
      end
    end else if (p <= ADDR_USER_LAST) begin
      // (RQ27) volatile space here reads zero
      v = access_control.volatile_select ? 8'h00 : nv_mem[p[2:0]];
    end else if (p == ADDR_ACCESS_CTL) begin
      // (RQ28) low bits read zero
      v = 8'h00;
      v[ACR_VOL_BIT] = access_control.volatile_select;
      v[ACR_POWER_DOWN_CTRL_BIT] = access_control.power_down_ctrl;
      v[ACR_WIP_BIT] = nv_busy;
    end
    return v;
  endfunction : reg_read

  // ----------------------------------------------------------------
  // byte framing and protocol state
  // ----------------------------------------------------------------
  dwp_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txbyte;
  logic ack_req;
  logic [7:0] rx_byte;
  logic byte_done;
  logic wr_en;
  logic ack_clk;
  assign rx_byte = {shreg[6:0], rxb_s};
  assign byte_done = bit_evt & (bitcnt == 4'h7);
  assign ack_clk = bit_evt & (bitcnt == 4'h8);
  // (RQ10) no writes while storage busy
  assign wr_en = byte_done & (state == ST_WR) & ~nv_busy;
  // shift register, msb first
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shreg <= 8'h00;
    end else if (bit_evt) begin
      // (RQ12) shift in msb first
      shreg <= {shreg[6:0], rxb_s};
    end
  end
  // protocol sequencer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      ack_req <= 1'b0;
      ptr <= 4'h0;
      txbyte <= 8'h00;
    end else if (start_evt) begin
      // (RQ23) repeated start also lands here
      state <= ST_ID;
      bitcnt <= 4'h0;
      ack_req <= 1'b0;
    end else if (stop_evt) begin
      // (RQ16) back to standby
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      ack_req <= 1'b0;
    end else if (bit_evt && state != ST_IDLE) begin
      if (bitcnt != 4'h8) begin
        bitcnt <= bitcnt + 4'h1;
      end else begin
        bitcnt <= 4'h0;
      end
      if (state == ST_RD && bitcnt != 4'h8) begin
        // sent bit done, move next one up
        txbyte <= {txbyte[6:0], 1'b0};
      end
      if (byte_done) begin
        case (state)
          ST_ID: begin
            // (RQ20) prefix and strap match
            if (rx_byte[7:4] == ID_PREFIX && rx_byte[3:1] == strap_s) begin
              // (RQ18) acknowledge identification
              ack_req <= 1'b1;
              state <= rx_byte[0] ? ST_RD : ST_REG;
            end else begin
              // (RQ26) no ack, wait for start
              state <= ST_IDLE;
            end
          end
          ST_REG: begin
            // (RQ25) pointer from address byte
            ptr <= rx_byte[3:0];
            ack_req <= 1'b1;
            state <= ST_WR;
          end
          ST_WR: begin
            // (RQ22) advance after each byte
            ptr <= next_ptr(ptr);
            ack_req <= 1'b1;
          end
          default: begin
            ack_req <= ack_req;
          end
        endcase
      end
      if (ack_clk) begin
        ack_req <= 1'b0;
        if (state == ST_RD) begin
          if (ack_req) begin
            // our ack done, first byte ready
            txbyte <= reg_read(ptr);
          end else if (!rxb_s) begin
            // (RQ25) master ack, next location
            ptr <= next_ptr(ptr);
            txbyte <= reg_read(next_ptr(ptr));
          end else begin
            // (RQ23) master nack ends the read
            state <= ST_IDLE;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // data line driver
  // ----------------------------------------------------------------
  // (RQ11) only data is ever driven
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (start_evt || stop_evt || powering_up) begin
      // (RQ14) released during power-up
      sda_oe_n <= 1'b1;
    end else if (scl_fall) begin
      // (RQ13) change only after clock falls
      if (bitcnt == 4'h8 && ack_req) begin
        // (RQ17) pull low on ninth clock
        sda_oe_n <= 1'b0;
      end else if (state == ST_RD && bitcnt != 4'h8) begin
        sda_oe_n <= txbyte[7];
      end else begin
        sda_oe_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  logic is_pot;
  logic is_user;
  assign is_pot = ptr <= ADDR_WIPER_1;
  assign is_user = ptr >= ADDR_USER_FIRST && ptr <= ADDR_USER_LAST;
  // non-volatile array
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nv_mem[0] <= POWER_ON_VALUE_RESET;
      nv_mem[1] <= POWER_ON_VALUE_RESET;
      for (int i = 2; i < 7; i++) begin
        nv_mem[i] <= USER_BYTE_RESET;
      end
    end else if (wr_en && !access_control.volatile_select && (is_pot || is_user)) begin
      // (RQ5) power-on values and user bytes
      nv_mem[ptr[2:0]] <= rx_byte;
    end
  end
  // wiper position registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // (RQ1) mid-scale during power-up
      wiper[0] <= WIPER_MID;
      wiper[1] <= WIPER_MID;
    end else if (pu_load) begin
      // (RQ2) recall stored power-on values
      wiper[0] <= nv_mem[0][6:0];
      wiper[1] <= nv_mem[1][6:0];
    end else if (wr_en && is_pot) begin
      // (RQ4) (RQ7) low bit picks the pot
      wiper[ptr[0]] <= rx_byte[6:0];
    end
  end
  // access control register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // (RQ8) (RQ9) reset defaults
      access_control.volatile_select <= ACR_VOL_RESET;
      access_control.power_down_ctrl <= ACR_POWER_DOWN_CTRL_RESET;
    end else if (wr_en && ptr == ADDR_ACCESS_CTL) begin
      // (RQ28) only top two bits stored
      access_control.volatile_select <= rx_byte[ACR_VOL_BIT];
      access_control.power_down_ctrl <= rx_byte[ACR_POWER_DOWN_CTRL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // self-timed non-volatile write
  // ----------------------------------------------------------------
  // (RQ24) armed by a write, started by stop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nv_pending <= 1'b0;
      nv_cnt <= 18'h00000;
    end else begin
      if (stop_evt && nv_pending) begin
        nv_cnt <= 18'(NV_CYCLES);
      end else if (nv_busy) begin
        nv_cnt <= nv_cnt - 18'h00001;
      end
      if (stop_evt) begin
        nv_pending <= 1'b0;
      end else if (wr_en && !access_control.volatile_select && (is_pot || is_user)) begin
        nv_pending <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // analog control outputs
  // ----------------------------------------------------------------
  // (RQ21) (RQ3) make tap follows code, main a cycle later
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tap_0 <= {WIPER_MID, WIPER_MID};
      tap_1 <= {WIPER_MID, WIPER_MID};
    end else begin
      tap_0.make_tap <= wiper[0];
      tap_0.main_tap <= tap_0.make_tap;
      tap_1.make_tap <= wiper[1];
      tap_1.main_tap <= tap_1.make_tap;
    end
  end
  // shutdown and status outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pot_shutdown <= 1'b0;
      nv_write_active <= 1'b0;
    end else begin
      // (RQ9) shutdown when bit and pin both low
      pot_shutdown <= ~(access_control.power_down_ctrl | power_down_ctrl_s);
      // (RQ10) busy flag
      nv_write_active <= nv_busy;
    end
  end

endmodule : dwp_slave

// [testbench/dwp_master.sv]
`timescale 1ns/1ns
module dwp_master (
  input wire logic clk_sys,
  output logic scl,
  output logic sda_m,
  input wire logic sda_in
);
  localparam int H = 6;
  // bus idles high, clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  task automatic hold();
    repeat (H) @(posedge clk_sys);
  endtask : hold

  // start or repeated start; the master alone drives the clock
  // master clocks bus
  task automatic start();
    sda_m <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_m <= 1'b0;
    hold();
    scl <= 1'b0;
    hold();
  endtask : start

  task automatic stop();
    sda_m <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda_m <= 1'b1;
    hold();
  endtask : stop

  // one clock; data set only in the low phase, sampled mid high
  // data changes low
  task automatic bit_io(input logic b, output logic s);
    sda_m <= b;
    hold();
    scl <= 1'b1;
    repeat (3) @(posedge clk_sys);
    s = sda_in;
    repeat (3) @(posedge clk_sys);
    scl <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : bit_io

  // byte out, then release the line for the ninth clock
  // msb first, release
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask : put

  // byte in, then acknowledge unless it is the last one
  // master acks reads
  task automatic get(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nack, s);
  endtask : get
endmodule : dwp_master

// [testbench/dwp_slave_chk.sv]
`timescale 1ns/1ns
module dwp_slave_chk
  import dwp_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic power_down_ctrl_n,
  input wire dwp_tap_t tap_0,
  input wire dwp_tap_t tap_1,
  input wire logic pot_shutdown,
  input wire logic nv_write_active
);
  int pu_cnt;
  int nv_cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // cycles since reset release, saturating
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pu_cnt <= 0;
    end else if (pu_cnt < 1000) begin
      pu_cnt <= pu_cnt + 1;
    end
  end

  // length of the running self-timed write
  always_ff @(posedge clk_sys) begin
    if (reset || !nv_write_active) begin
      nv_cnt <= 0;
    end else begin
      nv_cnt <= nv_cnt + 1;
    end
  end

  a_reset_state: assert property ($fell(reset) |-> sda_oe_n &&
    !nv_write_active && tap_0 == {2{WIPER_MID}} && tap_1 == {2{WIPER_MID}})
    else $error("outputs wrong after reset");
  a_powerup_quiet: assert property (pu_cnt < POWER_UP_CYCLES |-> sda_oe_n)
    else $error("data line driven during power-up");
  a_shutdown_or: assert property (power_down_ctrl_n[*6] |-> !pot_shutdown)
    else $error("shutdown while pin high");
  a_tap_make_break: assert property ($changed(tap_0.main_tap) |->
    tap_0.main_tap == $past(tap_0.make_tap))
    else $error("main tap moved before make tap");
  a_tap_follows: assert property ($changed(tap_1.make_tap) |=>
    tap_1.main_tap == $past(tap_1.make_tap))
    else $error("main tap did not follow make tap");
  a_drive_scl_low: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("data drive changed with clock high");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data output not low");
  a_nv_at_idle: assert property ($rose(nv_write_active) |-> scl && sda_in)
    else $error("write began outside stop");
  a_nv_max_len: assert property (nv_cnt <= NV_CYCLES + 2)
    else $error("self-timed write too long");
  a_nv_min_len: assert property ($fell(nv_write_active) |->
    nv_cnt >= NV_CYCLES - 2)
    else $error("self-timed write too short");
endmodule : dwp_slave_chk

bind dwp_slave dwp_slave_chk #(.NV_CYCLES(NV_CYCLES)) u_chk (
  .clk_sys(clk_sys), .reset(reset), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .power_down_ctrl_n(power_down_ctrl_n), .tap_0(tap_0), .tap_1(tap_1),
  .pot_shutdown(pot_shutdown), .nv_write_active(nv_write_active)
);

// [testbench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  import dwp_pkg::*;
  localparam int NV = 2000;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [2:0] straps = 3'h5;
  logic power_down_ctrl_n = 1'b1;
  logic sda_out, sda_oe_n, pot_shutdown, nv_write_active, scl, sda_m, ack;
  wire sda_in;
  dwp_tap_t tap_0, tap_1;
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] rd [4];

  // open-drain data wire with pull-up
  assign sda_in = sda_m & (sda_oe_n | sda_out);
  always #50 clk_sys = ~clk_sys;

  dwp_slave #(.NV_CYCLES(NV)) DUT (.clk_sys(clk_sys), .reset(reset),
    .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_strap_hi(straps[2]), .addr_strap_mid(straps[1]),
    .addr_strap_lo(straps[0]), .power_down_ctrl_n(power_down_ctrl_n),
    .tap_0(tap_0), .tap_1(tap_1), .pot_shutdown(pot_shutdown),
    .nv_write_active(nv_write_active));
  dwp_master MST (.clk_sys(clk_sys), .scl(scl), .sda_m(sda_m),
    .sda_in(sda_in));

  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : settle

  // identification and address bytes, each acknowledged
  // id byte format
  task automatic head(input logic [7:0] a);
    MST.start();
    MST.put({ID_PREFIX, straps, 1'b0}, ack);
    check(14'(ack), 14'h0);
    MST.put(a, ack);
    check(14'(ack), 14'h0);
  endtask : head

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
    head(a);
    for (int i = 0; i < n; i++) begin
      MST.put(d[15-8*i -: 8], ack);
      check(14'(ack), 14'h0);
    end
    MST.stop();
    settle();
  endtask : wr

  task automatic rdn(input logic [7:0] a, input int n);
    head(a);
    MST.start();
    MST.put({ID_PREFIX, straps, 1'b1}, ack);
    check(14'(ack), 14'h0);
    for (int i = 0; i < n; i++) MST.get(rd[i], i == n - 1);
    MST.stop();
    settle();
  endtask : rdn

  task automatic wait_nv(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && nv_write_active !== lvl; i++) begin
      @(posedge clk_sys);
    end
    if (i == lim) begin
      n_errors++;
      $display("mismatch at %0t: write flag wait ran out", $time);
      end_of_test();
    end
    #1;
  endtask : wait_nv

  // start during power-up, then a foreign address: both unanswered
  task automatic t_quiet();
    MST.start();
    MST.put({ID_PREFIX, straps, 1'b0}, ack);
    MST.stop();
    check(14'(ack), 14'h1);
    check(tap_0, {2{WIPER_MID}});
    check(14'(pot_shutdown), 14'h0);
    repeat (20) @(posedge clk_sys);
    MST.start();
    MST.put({ID_PREFIX, 3'h2, 1'b0}, ack);
    MST.stop();
    check(14'(ack), 14'h1);
  endtask : t_quiet

  // wiper-only writes, burst read across reserved, control and wrap
  task automatic t_volatile();
    wr(8'h08, 16'hC000, 1);
    wr(8'h00, 16'h7F00, 2);
    check(tap_0, {2{7'h7F}});
    check(tap_1, 14'h0);
    rdn(8'h07, 4);
    check(14'(rd[0]), 14'h0);
    check(14'(rd[1]), 14'hC0);
    check(14'(rd[2]), 14'h7F);
    check(14'(rd[3]), 14'h0);
    rdn(8'h02, 1);
    check(14'(rd[0]), 14'h0);
  endtask : t_volatile

  // stored write, blocking while it runs, read-back afterwards
  task automatic t_nonvolatile();
    wr(8'h08, 16'h4000, 1);
    check(14'(nv_write_active), 14'h0);
    wr(8'h00, 16'h2200, 1);
    wait_nv(1'b1, 20);
    check(tap_0, {2{7'h22}});
    wr(8'h01, 16'h3300, 1);
    check(tap_1, 14'h0);
    rdn(8'h08, 1);
    check(14'(rd[0]), 14'h60);
    wait_nv(1'b0, 3000);
    rdn(8'h00, 2);
    check(14'(rd[0]), 14'h22);
    check(14'(rd[1]), 14'h40);
  endtask : t_nonvolatile

  // shutdown bit cleared: pin alone decides
  task automatic t_shutdown();
    wr(8'h08, 16'h0000, 1);
    check(14'(pot_shutdown), 14'h0);
    @(posedge clk_sys);
    power_down_ctrl_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    check(14'(pot_shutdown), 14'h1);
    @(posedge clk_sys);
    power_down_ctrl_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    check(14'(pot_shutdown), 14'h0);
  endtask : t_shutdown

  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_quiet();
    t_volatile();
    t_nonvolatile();
    t_shutdown();
    end_of_test();
  end
endmodule : tb_top
